// ---- logic/sci_core.sv ----
`timescale 1ns/100ps
// Operation
// R1: Accept clock modes 0,0 and 1,1 only.
// R2: Sample input on each rising clock edge.
// R3: Change output on each falling clock edge.
// R4: First byte after select is the instruction.
// R5: Reset instruction restores defaults, configuration mode.
// R6: Host should reset during power-on initialization.
// R7: Read takes address, then shifts register out.
// R8: Read pointer advances after every byte out.
// R9: Quick receive read presets one of four.
// R10: Select rise clears read buffer's full flag.
// R11: Write takes address, then consecutive data bytes.
// R12: Commit on last bit; partial byte discarded.
// R13: Quick load presets one of six locations.
// R14: Request bits set each selected transmit buffer.
// R15: Request with no buffers selected does nothing.
// R16: Status poll repeats status while clocking continues.
// R17: Receive status poll repeats same bits.
// R18: Host sends address, mask, data in one selection.
// R19: Masked write changes only mask-enabled bits.
// R20: Unmaskable register takes mask as all ones.
// R21: Only some registers honour per-bit masking.
// R22: Unknown instruction ignored; output released when deselected.
// R23: Deselect aborts, clears counters, awaits instruction.
module sci_core (
   // Clock and reset.
   input  wire logic          core_clk,
   input  wire logic          rstn,
   // Serial link pins.
   input  wire logic          spi_sck,
   input  wire logic          spi_cs_n,
   input  wire logic          spi_si,
   output logic               spi_so,
   output logic               spi_so_oe_n,
   // Register write port.
   output sci_pkg::sci_wr_t   reg_wr,
   // Register read port; data is expected the cycle after the request.
   output logic               reg_rd_en,
   output logic [7:0]         reg_rd_addr,
   input  wire logic [7:0]    reg_rd_data,
   // Status inputs for the quick polls.
   input  wire logic [7:0]    read_status,
   input  wire logic [7:0]    rx_status,
   // Control strobes to the rest of the controller.
   output logic               soft_reset,
   output logic [2:0]         tx_req_set,
   output logic [1:0]         rx_flag_clr
);

   sci_pkg::sci_edge_t    ev;         // Synchronised link events.
   sci_pkg::sci_core_st_t st_r;       // All decoder state.
   sci_pkg::sci_core_st_t st_nxt;     // Next value of the state.
   logic [7:0]            byte_w;     // Byte including the bit taken this edge.
   logic                  done_w;     // This rising edge completes a byte.
   logic                  fetch_w;    // Start a register read this cycle.
   logic [7:0]            fetch_addr; // Address of that register read.
   logic [7:0]            wmask_w;    // Mask applied to a masked write.

   // Pins are synchronised before any decoding logic looks at them.
   sci_pin_sync u_sync (
      .core_clk (core_clk),
      .rstn     (rstn),
      .spi_sck  (spi_sck),
      .spi_cs_n (spi_cs_n),
      .spi_si   (spi_si),
      .ev       (ev)
   );

   // Output shifter; a byte starts at a fall while the bit counter is at zero.
   sci_so_shift u_so (
      .core_clk    (core_clk),
      .rstn        (rstn),
      .ev          (ev),
      .start       (st_r.bitcnt == sci_pkg::BIT_FIRST),
      .byte_in     (st_r.txbyte),
      .spi_so      (spi_so),
      .spi_so_oe_n (spi_so_oe_n)
   );

   // The incoming byte is most significant bit first.
   assign byte_w = {st_r.shin[6:0], ev.si};
   assign done_w = ev.sck_rise && (st_r.bitcnt == sci_pkg::BIT_LAST); // [R12]

   // Unmaskable registers see an all-ones mask, so the data byte lands whole.
   assign wmask_w = sci_pkg::bitmod_ok(st_r.ptr) ? st_r.mask : sci_pkg::FULL_MASK; // [R20] [R21]

   // Decoder next-state logic.
   always_comb begin
      st_nxt            = st_r;
      fetch_w           = 1'b0;
      fetch_addr        = st_r.ptr;
      // Strobes last one cycle.
      st_nxt.wr.en      = 1'b0;
      st_nxt.rd_en      = 1'b0;
      st_nxt.soft_reset = 1'b0;
      st_nxt.tx_req     = '0;
      st_nxt.rx_clr     = '0;
      // Read data returns one cycle after the request and waits for its byte start.
      st_nxt.rd_wait    = st_r.rd_en;
      if (st_r.rd_wait) begin
         st_nxt.txbyte = reg_rd_data; // [R7]
      end
      if (ev.cs_rise) begin
         // Deselect ends any instruction; a partial byte is simply dropped. [R12]
         if (st_r.rx_armed) begin
            st_nxt.rx_clr[st_r.rx_sel] = 1'b1; // [R10]
         end
         st_nxt.state    = sci_pkg::ST_CMD; // [R23]
         st_nxt.opk      = sci_pkg::OPK_NONE;
         st_nxt.bitcnt   = sci_pkg::BIT_FIRST; // [R23]
         st_nxt.shin     = '0;
         st_nxt.txbyte   = '0;
         st_nxt.rx_armed = 1'b0;
      end else if (ev.sck_rise) begin
         st_nxt.shin   = byte_w; // [R2]
         st_nxt.bitcnt = st_r.bitcnt + 3'h1;
         if (done_w) begin
            case (st_r.state)
               // Only the first byte of a selection is decoded as an instruction. [R4]
               sci_pkg::ST_CMD: begin
                  st_nxt.state = sci_pkg::ST_IGNORE; // [R22]
                  if (byte_w == sci_pkg::OP_RESET) begin
                     st_nxt.soft_reset = 1'b1; // [R5]
                  end else if (byte_w == sci_pkg::OP_READ) begin
                     st_nxt.opk   = sci_pkg::OPK_READ; // [R7]
                     st_nxt.state = sci_pkg::ST_ADDR;
                  end else if (byte_w == sci_pkg::OP_WRITE) begin
                     st_nxt.opk   = sci_pkg::OPK_WRITE; // [R11]
                     st_nxt.state = sci_pkg::ST_ADDR;
                  end else if (byte_w == sci_pkg::OP_MODIFY) begin
                     st_nxt.opk   = sci_pkg::OPK_MODIFY;
                     st_nxt.state = sci_pkg::ST_ADDR;
                  end else if (byte_w == sci_pkg::OP_RD_STAT) begin
                     st_nxt.txbyte = read_status; // [R16]
                     st_nxt.state  = sci_pkg::ST_STAT;
                  end else if (byte_w == sci_pkg::OP_RX_STAT) begin
                     st_nxt.txbyte = rx_status; // [R17]
                     st_nxt.state  = sci_pkg::ST_RXSTAT;
                  end else if ((byte_w & sci_pkg::OP_RXBUF_MASK) == sci_pkg::OP_RXBUF_VAL) begin
                     fetch_w         = 1'b1;
                     fetch_addr      = sci_pkg::rxbuf_addr(byte_w[2], byte_w[1]); // [R9]
                     st_nxt.rx_armed = 1'b1; // [R10]
                     st_nxt.rx_sel   = byte_w[2];
                     st_nxt.state    = sci_pkg::ST_RDATA;
                  end else if (((byte_w & sci_pkg::OP_LDTX_MASK) == sci_pkg::OP_LDTX_VAL) &&
                               (byte_w[2:1] != sci_pkg::LDTX_BAD_SEL)) begin
                     st_nxt.ptr   = sci_pkg::ldtx_addr(byte_w[2:0]); // [R13]
                     st_nxt.state = sci_pkg::ST_WDATA;
                  end else if ((byte_w & sci_pkg::OP_RTS_MASK) == sci_pkg::OP_RTS_VAL) begin
                     // A zero selector leaves every request bit alone. [R15]
                     st_nxt.tx_req = byte_w[2:0]; // [R14]
                  end
               end
               // The address byte picks the first register of the operation.
               sci_pkg::ST_ADDR: begin
                  if (st_r.opk == sci_pkg::OPK_READ) begin
                     fetch_w      = 1'b1;
                     fetch_addr   = byte_w; // [R7]
                     st_nxt.state = sci_pkg::ST_RDATA;
                  end else if (st_r.opk == sci_pkg::OPK_WRITE) begin
                     st_nxt.ptr   = byte_w; // [R11]
                     st_nxt.state = sci_pkg::ST_WDATA;
                  end else begin
                     st_nxt.ptr   = byte_w;
                     st_nxt.state = sci_pkg::ST_MASK;
                  end
               end
               // Each byte sent prefetches the next register, so reads stream on. [R8]
               sci_pkg::ST_RDATA: begin
                  fetch_w = 1'b1;
               end
               // Each full data byte is committed on its last rising edge. [R12]
               sci_pkg::ST_WDATA: begin
                  st_nxt.wr.en   = 1'b1;
                  st_nxt.wr.addr = st_r.ptr;
                  st_nxt.wr.data = byte_w;
                  st_nxt.wr.mask = sci_pkg::FULL_MASK;
                  st_nxt.ptr     = st_r.ptr + 8'h01; // [R11]
               end
               sci_pkg::ST_MASK: begin
                  st_nxt.mask  = byte_w;
                  st_nxt.state = sci_pkg::ST_MDATA;
               end
               // The register file merges data under the mask. [R19]
               sci_pkg::ST_MDATA: begin
                  st_nxt.wr.en   = 1'b1;
                  st_nxt.wr.addr = st_r.ptr;
                  st_nxt.wr.data = byte_w;
                  st_nxt.wr.mask = wmask_w; // [R20]
                  st_nxt.state   = sci_pkg::ST_IGNORE;
               end
               // The status polls reload fresh status for every further byte.
               sci_pkg::ST_STAT: begin
                  st_nxt.txbyte = read_status; // [R16]
               end
               sci_pkg::ST_RXSTAT: begin
                  st_nxt.txbyte = rx_status; // [R17]
               end
               default: begin
                  st_nxt.state = sci_pkg::ST_IGNORE;
               end
            endcase
         end
      end
      // A read request goes out now and the pointer moves past it. [R8]
      if (fetch_w) begin
         st_nxt.rd_en   = 1'b1;
         st_nxt.rd_addr = fetch_addr;
         st_nxt.ptr     = fetch_addr + 8'h01;
      end
   end

   // Register the decoder state.
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         st_r       <= '0;
         st_r.state <= sci_pkg::ST_CMD;
         st_r.opk   <= sci_pkg::OPK_NONE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs come straight from the state flops.
   assign reg_wr      = st_r.wr;
   assign reg_rd_en   = st_r.rd_en;
   assign reg_rd_addr = st_r.rd_addr;
   assign soft_reset  = st_r.soft_reset;
   assign tx_req_set  = st_r.tx_req;
   assign rx_flag_clr = st_r.rx_clr;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);

   // Address byte of a read completes.
   sequence read_addr_s;
      (st_r.state == sci_pkg::ST_ADDR) && (st_r.opk == sci_pkg::OPK_READ) && done_w;
   endsequence

   // The register is requested, then its data is taken into the send byte.
   sequence read_fetch_s(logic [7:0] a, logic [7:0] d);
      (reg_rd_en && reg_rd_addr == a) ##1 1'b1 ##1 (st_r.txbyte == d || ev.cs_rise);
   endsequence

   read_addr_a: assert property ( // [R7]
      read_addr_s |=> read_fetch_s($past(byte_w), $past(reg_rd_data, 1)))
      else $error("read address not fetched");

   ptr_inc_a: assert property ( // [R8]
      ((st_r.state == sci_pkg::ST_RDATA) && done_w) |=> (st_r.ptr == $past(st_r.ptr) + 8'h01))
      else $error("read pointer did not advance");

   cmd_reset_a: assert property ( // [R5]
      ((st_r.state == sci_pkg::ST_CMD) && done_w && byte_w == sci_pkg::OP_RESET) |=> soft_reset ##1 !soft_reset)
      else $error("reset instruction not one pulse");

   rxbuf_ptr_a: assert property ( // [R9]
      ((st_r.state == sci_pkg::ST_CMD) && done_w && (byte_w & sci_pkg::OP_RXBUF_MASK) == sci_pkg::OP_RXBUF_VAL)
      |=> reg_rd_en && reg_rd_addr == sci_pkg::rxbuf_addr($past(byte_w[2]), $past(byte_w[1])))
      else $error("receive buffer start address wrong");

   rx_clear_a: assert property ( // [R10]
      (ev.cs_rise && st_r.rx_armed) |=> (rx_flag_clr == (2'h1 << $past(st_r.rx_sel))))
      else $error("receive flag not cleared on deselect");

   wr_commit_a: assert property ( // [R12]
      ((st_r.state == sci_pkg::ST_WDATA) && done_w)
      |=> reg_wr.en && reg_wr.data == $past(byte_w) && reg_wr.mask == sci_pkg::FULL_MASK)
      else $error("data byte not committed");

   ldtx_ptr_a: assert property ( // [R13]
      ((st_r.state == sci_pkg::ST_CMD) && done_w && (byte_w & sci_pkg::OP_LDTX_MASK) == sci_pkg::OP_LDTX_VAL
       && byte_w[2:1] != sci_pkg::LDTX_BAD_SEL)
      |=> (st_r.ptr == sci_pkg::ldtx_addr($past(byte_w[2:0]))) && (st_r.state == sci_pkg::ST_WDATA))
      else $error("load pointer wrong");

   rts_set_a: assert property ( // [R14]
      ((st_r.state == sci_pkg::ST_CMD) && done_w && (byte_w & sci_pkg::OP_RTS_MASK) == sci_pkg::OP_RTS_VAL)
      |=> (tx_req_set == $past(byte_w[2:0])) ##1 (tx_req_set == 3'h0))
      else $error("transmit request bits wrong");

   mod_force_a: assert property ( // [R20]
      ((st_r.state == sci_pkg::ST_MDATA) && done_w && !sci_pkg::bitmod_ok(st_r.ptr))
      |=> reg_wr.en && reg_wr.mask == sci_pkg::FULL_MASK)
      else $error("mask not forced to all ones");

   cs_abort_a: assert property ( // [R23]
      ev.cs_rise |=> (st_r.state == sci_pkg::ST_CMD) && (st_r.bitcnt == sci_pkg::BIT_FIRST) && !reg_wr.en)
      else $error("deselect did not abort");

endmodule

// ---- common/sci_pkg.sv ----
package sci_pkg;

   // Instruction opcodes, compared against the first byte of a selection.
   localparam logic [7:0] OP_RESET      = 8'hC0;
   localparam logic [7:0] OP_READ       = 8'h03;
   localparam logic [7:0] OP_WRITE      = 8'h02;
   localparam logic [7:0] OP_MODIFY     = 8'h05;
   localparam logic [7:0] OP_RD_STAT    = 8'hA0;
   localparam logic [7:0] OP_RX_STAT    = 8'hB0;

   // Opcode families whose low bits carry a selector; match is (byte & mask) == value.
   localparam logic [7:0] OP_RXBUF_MASK = 8'hF9;
   localparam logic [7:0] OP_RXBUF_VAL  = 8'h90;
   localparam logic [7:0] OP_LDTX_MASK  = 8'hF8;
   localparam logic [7:0] OP_LDTX_VAL   = 8'h40;
   localparam logic [7:0] OP_RTS_MASK   = 8'hF8;
   localparam logic [7:0] OP_RTS_VAL    = 8'h80;

   // The load selector values 110 and 111 name no buffer location.
   localparam logic [1:0] LDTX_BAD_SEL  = 2'h3;

   // Bit counter width and the index of the last bit in a byte.
   localparam int         BIT_CNT_W     = 3;
   localparam logic [2:0] BIT_LAST      = 3'h7;
   localparam logic [2:0] BIT_FIRST     = 3'h0;

   // A mask with every bit enabled, used for plain byte writes.
   localparam logic [7:0] FULL_MASK     = 8'hFF;

   // Buffer locations that the quick load and quick read commands point at.
   localparam logic [7:0] TXB_ID_ADDR0  = 8'h31;
   localparam logic [7:0] RXB_ID_ADDR0  = 8'h61;
   localparam logic [7:0] BUF_STRIDE    = 8'h10;
   localparam logic [7:0] BUF_DATA_OFS  = 8'h05;

   // Addresses of registers that honour per-bit masking.
   localparam logic [7:0] ADDR_PIN_CTRL = 8'h0C;
   localparam logic [7:0] ADDR_RTS_CTRL = 8'h0D;
   localparam logic [7:0] ADDR_CFG_LO   = 8'h28;
   localparam logic [7:0] ADDR_CFG_HI   = 8'h2D;
   localparam logic [3:0] NIB_STATUS    = 4'hE;
   localparam logic [3:0] NIB_MODE      = 4'hF;
   localparam logic [3:0] NIB_BUF_CTRL  = 4'h0;
   localparam logic [3:0] HI_BUF_LO     = 4'h3;
   localparam logic [3:0] HI_BUF_HI     = 4'h7;

   // Decoder states.
   typedef enum logic [3:0] {
      ST_CMD    = 4'h0,
      ST_ADDR   = 4'h1,
      ST_RDATA  = 4'h2,
      ST_WDATA  = 4'h3,
      ST_MASK   = 4'h4,
      ST_MDATA  = 4'h5,
      ST_STAT   = 4'h6,
      ST_RXSTAT = 4'h7,
      ST_IGNORE = 4'h8
   } sci_state_t;

   // Which addressed operation the address byte belongs to.
   typedef enum logic [1:0] {
      OPK_NONE   = 2'h0,
      OPK_READ   = 2'h1,
      OPK_WRITE  = 2'h2,
      OPK_MODIFY = 2'h3
   } sci_opk_t;

   // Synchronised serial-link signals; the edge events are one core clock wide, cs_act and si are levels.
   typedef struct packed {
      logic cs_act;
      logic cs_rise;
      logic sck_rise;
      logic sck_fall;
      logic si;
   } sci_edge_t;

   // One register write towards the register file.
   typedef struct packed {
      logic       en;
      logic [7:0] addr;
      logic [7:0] data;
      logic [7:0] mask;
   } sci_wr_t;

   // Pin synchroniser state.
   typedef struct packed {
      logic      sck1;
      logic      sck2;
      logic      sck3;
      logic      cs1;
      logic      cs2;
      logic      cs3;
      logic      si1;
      logic      si2;
      sci_edge_t ev;
   } sci_sync_st_t;

   // Serial output shifter state.
   typedef struct packed {
      logic       so;
      logic       oe_n;
      logic [6:0] sh;
   } sci_so_st_t;

   // Decoder state.
   typedef struct packed {
      sci_state_t state;
      sci_opk_t   opk;
      logic [2:0] bitcnt;
      logic [7:0] shin;
      logic [7:0] ptr;
      logic [7:0] mask;
      logic [7:0] txbyte;
      logic       rd_wait;
      logic       rx_armed;
      logic       rx_sel;
      sci_wr_t    wr;
      logic       rd_en;
      logic [7:0] rd_addr;
      logic       soft_reset;
      logic [2:0] tx_req;
      logic [1:0] rx_clr;
   } sci_core_st_t;

   // Start address of a transmit buffer's identifier or data field.
   function automatic logic [7:0] ldtx_addr(input logic [2:0] sel);
      logic [7:0] a;
      a = TXB_ID_ADDR0;
      if (sel[2:1] == 2'h1) a = a + BUF_STRIDE;
      if (sel[2:1] == 2'h2) a = a + BUF_STRIDE + BUF_STRIDE;
      if (sel[0]) a = a + BUF_DATA_OFS;
      return a;
   endfunction

   // Start address of a receive buffer's identifier or data field.
   function automatic logic [7:0] rxbuf_addr(input logic n, input logic m);
      logic [7:0] a;
      a = RXB_ID_ADDR0;
      if (n) a = a + BUF_STRIDE;
      if (m) a = a + BUF_DATA_OFS;
      return a;
   endfunction

   // True where the register accepts a per-bit mask.
   function automatic logic bitmod_ok(input logic [7:0] a);
      return (a == ADDR_PIN_CTRL) || (a == ADDR_RTS_CTRL) ||
             (a[3:0] == NIB_STATUS) || (a[3:0] == NIB_MODE) ||
             ((a >= ADDR_CFG_LO) && (a <= ADDR_CFG_HI)) ||
             ((a[3:0] == NIB_BUF_CTRL) && (a[7:4] >= HI_BUF_LO) && (a[7:4] <= HI_BUF_HI));
   endfunction

endpackage

// ---- logic/sci_pin_sync.sv ----
`timescale 1ns/100ps
module sci_pin_sync (
   // Clock and reset.
   input  wire logic          core_clk,
   input  wire logic          rstn,
   // Serial link pins, asynchronous to the core clock.
   input  wire logic          spi_sck,
   input  wire logic          spi_cs_n,
   input  wire logic          spi_si,
   // Registered link events.
   output sci_pkg::sci_edge_t ev
);

   sci_pkg::sci_sync_st_t st_r;   // All synchroniser state.
   sci_pkg::sci_sync_st_t st_nxt; // Next value of the state.

   // Two flops per pin, then a third stage for edge finding on clock and select.
   // The first stage of each pin feeds only the second stage.
   always_comb begin
      st_nxt             = st_r;
      st_nxt.sck1        = spi_sck;
      st_nxt.sck2        = st_r.sck1;
      st_nxt.sck3        = st_r.sck2;
      st_nxt.cs1         = spi_cs_n;
      st_nxt.cs2         = st_r.cs1;
      st_nxt.cs3         = st_r.cs2;
      st_nxt.si1         = spi_si;
      st_nxt.si2         = st_r.si1;
      st_nxt.ev.cs_act   = ~st_r.cs2;
      st_nxt.ev.cs_rise  = st_r.cs2 & ~st_r.cs3;
      // Clock edges count only while selected; both modes share one edge meaning. [R1]
      st_nxt.ev.sck_rise = st_r.sck2 & ~st_r.sck3 & ~st_r.cs2; // [R2]
      st_nxt.ev.sck_fall = ~st_r.sck2 & st_r.sck3 & ~st_r.cs2; // [R3]
      // Data is taken from the same stage as the clock so the two stay aligned.
      st_nxt.ev.si       = st_r.si2;
   end

   // Register the state; select idles high so no false edge follows reset.
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         st_r      <= '0;
         st_r.cs1  <= 1'b1;
         st_r.cs2  <= 1'b1;
         st_r.cs3  <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign ev = st_r.ev;

   // A synchronised rising clock while selected is reported on the next edge.
   sck_rise_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R2]
      (st_r.sck2 && !st_r.sck3 && !st_r.cs2) |=> ev.sck_rise)
      else $error("rising clock edge not reported");

endmodule

// ---- logic/sci_so_shift.sv ----
`timescale 1ns/100ps
module sci_so_shift (
   // Clock and reset.
   input  wire logic          core_clk,
   input  wire logic          rstn,
   // Link events and the byte to send.
   input  sci_pkg::sci_edge_t ev,
   input  wire logic          start,
   input  wire logic [7:0]    byte_in,
   // Serial output pin.
   output logic               spi_so,
   output logic               spi_so_oe_n
);

   sci_pkg::sci_so_st_t st_r;   // All shifter state.
   sci_pkg::sci_so_st_t st_nxt; // Next value of the state.

   // Each falling clock presents the next bit; the first fall of a byte loads it.
   always_comb begin
      st_nxt      = st_r;
      st_nxt.oe_n = ~ev.cs_act; // [R22]
      if (!ev.cs_act) begin
         // Deselected: the pin is released and the shifter emptied.
         st_nxt.so = 1'b0;
         st_nxt.sh = '0;
      end else if (ev.sck_fall) begin
         if (start) begin
            {st_nxt.so, st_nxt.sh} = byte_in; // [R3]
         end else begin
            {st_nxt.so, st_nxt.sh} = {st_r.sh, 1'b0}; // [R3]
         end
      end
   end

   // Register the state; the pin is released during reset.
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         st_r      <= '0;
         st_r.oe_n <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign spi_so      = st_r.so;
   assign spi_so_oe_n = st_r.oe_n;

   // The first bit of a byte is its top bit, driven right after the fall.
   so_first_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R3]
      (ev.cs_act && ev.sck_fall && start) |=> (spi_so == $past(byte_in[7])))
      else $error("first output bit is not the top bit");

   // The output is released one edge after select goes inactive.
   so_release_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R22]
      !ev.cs_act |=> spi_so_oe_n)
      else $error("output driven while deselected");

endmodule

// ---- verif/sci_host.sv ----
`timescale 1ns/100ps
// Host acting as serial master; the clock rests at its idle level between frames.
module sci_host (
   // Serial pins towards the device.
   output logic      spi_sck,
   output logic      spi_cs_n,
   output logic      spi_si,
   input  wire logic spi_so
);
   logic mode; // Idle clock level: 0 for mode 0,0 and 1 for mode 1,1.
   initial begin
      mode = 1'b0;
      spi_sck = 1'b0;
      spi_cs_n = 1'b1;
      spi_si = 1'b0;
   end
   // Select the device once the clock stands at its idle level.
   task automatic sel(input logic m);
      mode = m;
      spi_sck = m;
      #160 spi_cs_n = 1'b0;
      #160;
   endtask
   // Shift n bits MSB first; the output is read late in the high phase so the device has settled.
   task automatic xb(input logic [7:0] b, input int n, output logic [7:0] r);
      for (int i = 7; i > 7 - n; i--) begin
         spi_sck = 1'b0;
         spi_si = b[i];
         #160 spi_sck = 1'b1;
         #160 r = {r[6:0], spi_so};
      end
   endtask
   // Deselect; the data line toggles so a stale level is never mistaken for data.
   task automatic desel();
      spi_sck = mode;
      #160 spi_cs_n = 1'b1;
      spi_si = ~spi_si;
      #480;
   endtask
endmodule

// ---- verif/sci_core_bench.sv ----
`timescale 1ns/100ps
module sci_core_bench;
   logic             core_clk = 1'b0; // 25 MHz core clock.
   logic             rstn = 1'b0;     // Synchronous reset, active low.
   logic             spi_sck, spi_cs_n, spi_si, spi_so, spi_so_oe_n, reg_rd_en, soft_reset;
   sci_pkg::sci_wr_t reg_wr;
   logic [7:0]       reg_rd_addr, reg_rd_data, read_status, rx_status, a, d, m, t;
   logic [2:0]       tx_req_set, tx_seen;
   logic [1:0]       rx_flag_clr, rx_seen;
   logic [7:0]       mem [256];   // Register file behind the block.
   logic [7:0]       exp_m [256]; // Contents the bench expects.
   logic [7:0]       rv [4];      // Bytes returned in the last frame.
   int               miscompares = 0, comparisons = 0, resets = 0;
   integer           seed = 4418;
   always #20 core_clk = ~core_clk;
   sci_core uut (.core_clk(core_clk), .rstn(rstn), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si),
      .spi_so(spi_so), .spi_so_oe_n(spi_so_oe_n), .reg_wr(reg_wr), .reg_rd_en(reg_rd_en), .reg_rd_addr(reg_rd_addr),
      .reg_rd_data(reg_rd_data), .read_status(read_status), .rx_status(rx_status), .soft_reset(soft_reset),
      .tx_req_set(tx_req_set), .rx_flag_clr(rx_flag_clr));
   sci_host u_host (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_so(spi_so_oe_n ? 1'bz : spi_so));
   // Register file with one cycle of read latency; it also gathers the control strobes.
   always @(posedge core_clk) begin
      reg_rd_data <= mem[reg_rd_addr];
      if (reg_wr.en) mem[reg_wr.addr] <= (mem[reg_wr.addr] & ~reg_wr.mask) | (reg_wr.data & reg_wr.mask);
      tx_seen <= tx_seen | tx_req_set;
      rx_seen <= rx_seen | rx_flag_clr;
      resets <= resets + int'(soft_reset);
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] want);
      comparisons++;
      if (got !== want) begin
         miscompares++;
         $display("[FAIL] %0t ns: got %h, want %h", $time, got, want);
      end
   endtask
   task automatic end_sim();
      if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // One selection of nb bytes; the last byte is cut to lb bits.
   task automatic frame(input logic md, input logic [31:0] bs, input int nb, input int lb);
      u_host.sel(md);
      for (int k = 0; k < nb; k++) u_host.xb(bs[31-8*k -: 8], (k == nb - 1) ? lb : 8, rv[k]);
      u_host.desel();
   endtask
   // Read one register back and compare it with the expected contents.
   task automatic rdchk(input logic [7:0] ad);
      frame(1'b0, {8'h03, ad, 16'h0}, 3, 8);
      chk(rv[2], exp_m[ad]);
      chk({7'h0, spi_so_oe_n}, 8'h01);
   endtask
   initial begin
      #2_000_000;
      miscompares++;
      end_sim();
   end
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = 8'(i * 7);
         exp_m[i] = 8'(i * 7);
      end
      {reg_rd_data, read_status, rx_status, tx_seen, rx_seen} = 29'h0;
      repeat (5) @(negedge core_clk);
      rstn = 1'b1;
      repeat (4) @(negedge core_clk);
      // Random two-byte writes, read back in the other clock mode.
      repeat (4) begin
         {a, d, m} = 24'($random(seed));
         frame(1'b0, {8'h02, a, d, m}, 4, 8);
         exp_m[a] = d;
         exp_m[8'(a + 1)] = m;
         frame(1'b1, {8'h03, a, 16'h0}, 4, 8);
         chk(rv[2], exp_m[a]);
         chk(rv[3], exp_m[8'(a + 1)]);
      end
      // A byte cut short at deselect is dropped, the one before it kept.
      frame(1'b0, {8'h02, a, 8'hA5, 8'h3C}, 4, 5);
      exp_m[a] = 8'hA5;
      rdchk(a);
      rdchk(8'(a + 1));
      // Masked write on a maskable and on a plain register.
      foreach (rv[j]) begin
         {d, m} = 16'($random(seed));
         t = j[0] ? 8'h31 : 8'h2C;
         frame(1'b0, {8'h05, t, m, d}, 4, 8);
         exp_m[t] = (exp_m[t] & ~(j[0] ? 8'hFF : m)) | (d & (j[0] ? 8'hFF : m));
         rdchk(t);
      end
      // Quick load into each of the six buffer locations.
      for (int s = 0; s < 6; s++) begin
         d = 8'($random(seed));
         t = 8'h31 + 8'(s / 2) * 8'h10 + (s[0] ? 8'h05 : 8'h00);
         frame(1'b0, {8'h40 | 8'(s), d, 16'h0}, 2, 8);
         exp_m[t] = d;
         rdchk(t);
      end
      // An unknown instruction must not act on the bytes that follow it.
      frame(1'b0, {8'hFF, 8'h02, 8'h12, 8'h34}, 4, 8);
      rdchk(8'h12);
      // Every transmit request selector, including none.
      for (int n = 0; n < 8; n++) begin
         tx_seen = 3'h0;
         frame(1'b0, {8'h80 | 8'(n), 24'h0}, 1, 8);
         chk({5'h0, tx_seen}, 8'(n));
      end
      // Quick receive reads of all four locations, each clearing its buffer's flag.
      for (int j = 0; j < 4; j++) begin
         rx_seen = 2'h0;
         t = 8'h61 + (j[1] ? 8'h10 : 8'h00) + (j[0] ? 8'h05 : 8'h00);
         frame(1'b0, {8'h90 | 8'(j * 2), 24'h0}, 2, 8);
         chk(rv[1], exp_m[t]);
         chk({6'h0, rx_seen}, j[1] ? 8'h02 : 8'h01);
      end
      // Both status polls repeat their word while clocking goes on.
      {read_status, rx_status} = 16'($random(seed));
      frame(1'b0, {8'hA0, 24'h0}, 3, 8);
      chk(rv[1], read_status);
      chk(rv[2], read_status);
      frame(1'b1, {8'hB0, 24'h0}, 3, 8);
      chk(rv[2], rx_status);
      frame(1'b0, {8'hC0, 24'h0}, 1, 8);
      chk(8'(resets), 8'h01);
      end_sim();
   end
endmodule
